// ---- hdl/nv_host_params.svh ----
// constants for the host-side nonvolatile command sequencer
// assumes a 10 MHz controller clock driving an asynchronous memory bus
`ifndef NV_HOST_PARAMS_SVH
`define NV_HOST_PARAMS_SVH

`define CLK_PERIOD_NS 100
// nonvolatile operation times in ns, plain defaults
`define T_STORE_NS 15000000
`define T_RECALL_NS 200
// clocks that chip select stays low per access, longer than the access time
`define ACC_CYC 3
`define SEQ_STEPS 6
`define SEQ_LAST 3'h5
// command sequence addresses, lower 16 lines only
`define SEQ_ADDR_0 16'h4E38
`define SEQ_ADDR_1 16'hB1C7
`define SEQ_ADDR_2 16'h83E0
`define SEQ_ADDR_3 16'h7C1F
`define SEQ_ADDR_4 16'h703F
`define SEQ_ADDR_SAVE 16'h8FC0
`define SEQ_ADDR_RECALL 16'h4C63
`define SEQ_ADDR_PLS_OFF 16'h8B45
`define SEQ_ADDR_PLS_ON 16'h4B46
// top address line held low during sequence reads
`define SEQ_A16 1'b0
// idle levels and cleared values loaded at reset
`define STROBE_OFF 1'b1
`define READY_RST 1'b1
`define ADDR_RST 17'h0_0000
`define DATA_RST 8'h00
`define STEP_FIRST 3'h0
`define TIMER_RST 32'h0000_0000

`endif

// ---- hdl/nv_host_pkg.sv ----
// types for the host-side nonvolatile command sequencer
// used by the sequencer module and its bench
package nv_host_pkg;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_SAVE = 3'h2,
    OP_RECALL = 3'h3,
    OP_POWER_LOSS_SAVE_OFF = 3'h4,
    OP_POWER_LOSS_SAVE_ON = 3'h5
  } op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_BUSY_WAIT = 7'h02,
    ST_SETUP = 7'h04,
    ST_ACCESS = 7'h08,
    ST_GAP = 7'h10,
    ST_NV_WAIT = 7'h20,
    ST_FINISH = 7'h40
  } seq_state_t;

  typedef struct packed {
    op_t op;
    logic [16:0] addr;
    logic [7:0] data;
  } nv_cmd_t;

  typedef struct packed {
    logic ce_b;
    logic we_b;
    logic oe_b;
    logic [16:0] addr;
    logic [7:0] dq;
    logic dq_drive_b;
  } mem_pins_t;

  typedef struct packed {
    logic valid;
    logic refused;
    logic [7:0] data;
  } nv_rsp_t;

  typedef struct packed {
    seq_state_t st;
    op_t op;
    logic [2:0] step;
    logic [31:0] timer;
    logic [16:0] cmd_addr;
    mem_pins_t pins;
    logic ready;
    nv_rsp_t rsp;
  } host_state_t;

endpackage : nv_host_pkg

// ---- hdl/pin_sync.sv ----
// two-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous pins; reset value is a constant parameter
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        meta_ff[i] <= RESET_VAL[i];
        sync_ff[i] <= RESET_VAL[i];
      end else begin
        meta_ff[i] <= async_in[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign sync_out = sync_ff;
endmodule : pin_sync

// ---- hdl/nv_host_seq.sv ----
// host controller that drives an asynchronous nonvolatile SRAM: plain reads and
// writes plus six-read command sequences for save, recall and power-loss save control
// assumes the memory pins and the supply-low flag are asynchronous to ref_clk_in
`timescale 1ns/100ps
`include "nv_host_params.svh"

module nv_host_seq
  import nv_host_pkg::*;
#(
  parameter int unsigned STORE_CYC = (`T_STORE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned RECALL_CYC = (`T_RECALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input nv_host_pkg::nv_cmd_t cmd_in,
  output logic cmd_ready_out,
  output nv_host_pkg::nv_rsp_t rsp_out,
  output nv_host_pkg::mem_pins_t pins_out,
  input wire logic [7:0] dq_in,
  input wire logic store_busy_line_b_in,
  input wire logic supply_low_in
);
  import nv_host_pkg::*;

  host_state_t cur_ff;
  host_state_t nxt_cur;
  logic [7:0] dq_sync;
  logic busy_b_sync;
  logic supply_low_sync;

  // strobes released, host free to take a command
  localparam mem_pins_t PINS_IDLE = '{
    ce_b: `STROBE_OFF,
    we_b: `STROBE_OFF,
    oe_b: `STROBE_OFF,
    addr: `ADDR_RST,
    dq: `DATA_RST,
    dq_drive_b: `STROBE_OFF
  };
  localparam host_state_t STATE_RST = '{
    st: ST_IDLE,
    op: OP_READ,
    step: `STEP_FIRST,
    timer: `TIMER_RST,
    cmd_addr: `ADDR_RST,
    pins: PINS_IDLE,
    ready: `READY_RST,
    rsp: '0
  };

  // busy line idles high and supply reads low until the first samples arrive
  pin_sync #(.W(10), .RESET_VAL(10'h100)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in({supply_low_in, store_busy_line_b_in, dq_in}),
    .sync_out({supply_low_sync, busy_b_sync, dq_sync})
  );

  function automatic logic [15:0] seq_addr(input logic [2:0] step, input op_t op);
    logic [15:0] a;
    a = `SEQ_ADDR_0;
    unique case (step)
      3'h0: a = `SEQ_ADDR_0;
      3'h1: a = `SEQ_ADDR_1;
      3'h2: a = `SEQ_ADDR_2;
      3'h3: a = `SEQ_ADDR_3;
      3'h4: a = `SEQ_ADDR_4;
      default: begin
        unique case (op)
          OP_RECALL: a = `SEQ_ADDR_RECALL;
          OP_POWER_LOSS_SAVE_OFF: a = `SEQ_ADDR_PLS_OFF;
          OP_POWER_LOSS_SAVE_ON: a = `SEQ_ADDR_PLS_ON;
          default: a = `SEQ_ADDR_SAVE;
        endcase
      end
    endcase
    return a;
  endfunction : seq_addr

  function automatic logic is_plain(input op_t op);
    return (op == OP_READ) || (op == OP_WRITE);
  endfunction : is_plain

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rsp.valid = 1'b0;
    nxt_cur.rsp.refused = 1'b0;
    unique case (cur_ff.st)
      ST_IDLE: begin
        if (cmd_valid_in && cur_ff.ready) begin
          nxt_cur.ready = 1'b0;
          // low supply: the memory would drop writes and saves, so refuse them here
          if (supply_low_sync && (cmd_in.op == OP_WRITE || cmd_in.op == OP_SAVE)) begin
            nxt_cur.rsp.valid = 1'b1;
            nxt_cur.rsp.refused = 1'b1;
            nxt_cur.ready = 1'b1;
          end else begin
            nxt_cur.op = cmd_in.op;
            nxt_cur.cmd_addr = cmd_in.addr;
            nxt_cur.pins.dq = cmd_in.data;
            nxt_cur.step = 3'h0;
            nxt_cur.st = ST_BUSY_WAIT;
          end
        end
      end
      ST_BUSY_WAIT: begin
        // a save in progress keeps the memory disabled
        if (busy_b_sync) begin
          nxt_cur.st = ST_SETUP;
          nxt_cur.pins.addr = is_plain(cur_ff.op) ? cur_ff.cmd_addr
                                                  : {`SEQ_A16, seq_addr(cur_ff.step, cur_ff.op)};
        end
      end
      ST_SETUP: begin
        // address settles one clock before chip select falls
        nxt_cur.pins.ce_b = 1'b0;
        if (cur_ff.op == OP_WRITE) begin
          nxt_cur.pins.we_b = 1'b0;
          nxt_cur.pins.dq_drive_b = 1'b0;
        end else begin
          nxt_cur.pins.we_b = 1'b1;
          nxt_cur.pins.oe_b = 1'b0;
        end
        nxt_cur.timer = 32'(`ACC_CYC - 1);
        nxt_cur.st = ST_ACCESS;
      end
      ST_ACCESS: begin
        if (cur_ff.timer == 32'h0) begin
          nxt_cur.rsp.data = dq_sync;
          // chip select and write rise together so every write starts on a fresh edge
          nxt_cur.pins.ce_b = 1'b1;
          nxt_cur.pins.we_b = 1'b1;
          nxt_cur.pins.oe_b = 1'b1;
          nxt_cur.st = ST_GAP;
        end else begin
          nxt_cur.timer = cur_ff.timer - 32'h1;
        end
      end
      ST_GAP: begin
        // write data outlives the strobes by one clock, a hold margin at the pins
        nxt_cur.pins.dq_drive_b = 1'b1;
        if (is_plain(cur_ff.op)) begin
          nxt_cur.rsp.valid = 1'b1;
          nxt_cur.ready = 1'b1;
          nxt_cur.st = ST_IDLE;
        end else if (cur_ff.step != `SEQ_LAST) begin
          // steps follow back to back with no other access between them
          nxt_cur.step = cur_ff.step + 3'h1;
          nxt_cur.pins.addr = {`SEQ_A16, seq_addr(cur_ff.step + 3'h1, cur_ff.op)};
          nxt_cur.st = ST_SETUP;
        end else begin
          unique case (cur_ff.op)
            OP_RECALL: begin
              nxt_cur.timer = 32'(RECALL_CYC - 1);
              nxt_cur.st = ST_NV_WAIT;
            end
            OP_POWER_LOSS_SAVE_OFF, OP_POWER_LOSS_SAVE_ON: begin
              // new setting only survives power-down once saved
              nxt_cur.op = OP_SAVE;
              nxt_cur.step = 3'h0;
              nxt_cur.st = ST_BUSY_WAIT;
            end
            default: begin
              nxt_cur.timer = 32'(STORE_CYC - 1);
              nxt_cur.st = ST_NV_WAIT;
            end
          endcase
        end
      end
      ST_NV_WAIT: begin
        if (cur_ff.timer == 32'h0) begin
          nxt_cur.st = ST_FINISH;
        end else begin
          nxt_cur.timer = cur_ff.timer - 32'h1;
        end
      end
      ST_FINISH: begin
        // save may outlast its nominal time; trust the busy line
        if (busy_b_sync) begin
          nxt_cur.rsp.valid = 1'b1;
          nxt_cur.ready = 1'b1;
          nxt_cur.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cur_ff <= STATE_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cmd_ready_out = cur_ff.ready;
  assign rsp_out = cur_ff.rsp;
  assign pins_out = cur_ff.pins;
endmodule : nv_host_seq

// ---- tb/nv_host_seq_chk.sv ----
// pin-level checks on the host nonvolatile sequencer
// sees only the top ports; bound in at the foot
`timescale 1ns/100ps
`include "nv_host_params.svh"
module nv_host_seq_chk
  import nv_host_pkg::*;
#(
  parameter int unsigned STORE_CYC = 20,
  parameter int unsigned RECALL_CYC = 2
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic cmd_valid_in,
  input nv_host_pkg::nv_cmd_t cmd_in,
  input wire logic cmd_ready_out,
  input nv_host_pkg::nv_rsp_t rsp_out,
  input nv_host_pkg::mem_pins_t pins_out,
  input wire logic [7:0] dq_in,
  input wire logic store_busy_line_b_in,
  input wire logic supply_low_in
);
  import nv_host_pkg::*;
  logic ce_d_ff;
  logic [15:0] prev_ff;
  logic fall;
  logic [15:0] a;
  assign a = pins_out.addr[15:0];
  assign fall = ce_d_ff & ~pins_out.ce_b;
  // last address that opened an access, for order checks
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ce_d_ff <= 1'b1;
      prev_ff <= 16'h0000;
    end else begin
      ce_d_ff <= pins_out.ce_b;
      if (fall) prev_ff <= a;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_no_read_write: assert property (!(!pins_out.oe_b && !pins_out.we_b))
    else $error("oe and we low together");
  a_seq_open: assert property (fall && a == `SEQ_ADDR_1 |-> prev_ff == `SEQ_ADDR_0)
    else $error("second step out of order");
  a_seq_tail: assert property (fall && a == `SEQ_ADDR_4 |-> prev_ff == `SEQ_ADDR_3)
    else $error("fifth step out of order");
  a_we_held: assert property (fall && pins_out.we_b |->
    (pins_out.we_b && !pins_out.ce_b)[*3] ##1 pins_out.ce_b)
    else $error("read access shape wrong");
  a_toggle_save: assert property (fall && a == `SEQ_ADDR_PLS_OFF |->
    ##[4:20] (fall && a == `SEQ_ADDR_0))
    else $error("no save after toggle");
  a_upper_low: assert property (fall && a == `SEQ_ADDR_0 |-> !pins_out.addr[16])
    else $error("top address line high");
  a_toggle_on: assert property (fall && a == `SEQ_ADDR_PLS_ON |->
    ##[4:20] (fall && a == `SEQ_ADDR_0))
    else $error("no save after enable");
  a_low_refuse: assert property (cmd_valid_in && cmd_ready_out && cmd_in.op == OP_WRITE &&
    $past(supply_low_in, 2) |=> rsp_out.valid && rsp_out.refused)
    else $error("write at low supply not refused");
endmodule : nv_host_seq_chk

bind nv_host_seq nv_host_seq_chk #(.STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC)) chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
  .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_out(rsp_out),
  .pins_out(pins_out), .dq_in(dq_in), .store_busy_line_b_in(store_busy_line_b_in),
  .supply_low_in(supply_low_in));

// ---- tb/nv_mem_model.sv ----
// behavioural nonvolatile memory with the six-read decoder
// assumes the bench resolves the data wire; small array aliases addresses
`timescale 1ns/100ps
`include "nv_host_params.svh"
module nv_mem_model
  import nv_host_pkg::*;
#(
  parameter int BUSY_CYC = 25
) (
  input wire logic ref_clk_in,
  input nv_host_pkg::mem_pins_t pins_in,
  input wire logic [7:0] dq_in,
  input wire logic supply_low_in,
  output logic [7:0] dq_out,
  output logic busy_b_out
);
  import nv_host_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] nv [0:255];
  logic [15:0] seq [0:4];
  logic [2:0] step = 3'h0;
  logic [15:0] a;
  logic pls_on = 1'b1;
  int saves = 0;
  int recalls = 0;
  int busy = 0;
  logic was_write = 1'b0;
  logic wr_armed = 1'b0;
  logic [7:0] wr_dq = 8'h00;
  initial seq = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2, `SEQ_ADDR_3, `SEQ_ADDR_4};
  assign busy_b_out = (busy == 0);
  // inverse of stored byte when not driving, so a stale bus is never read as good
  assign dq_out = (!pins_in.ce_b && !pins_in.oe_b && pins_in.we_b && busy == 0) ?
    mem[pins_in.addr[7:0]] : ~mem[pins_in.addr[7:0]];
  // strobes and chip select rise on one clock edge, with data drive released a clock later, so the
  // kind of access and its data are taken while the chip is still selected
  always @(posedge ref_clk_in) begin
    if (busy > 0) busy = busy - 1;
    if (!pins_in.ce_b) begin
      was_write = !pins_in.we_b;
      wr_dq = dq_in;
    end
  end
  always @(negedge pins_in.ce_b or negedge pins_in.we_b) wr_armed = 1'b1;
  always @(posedge pins_in.ce_b) begin
    a = pins_in.addr[15:0];
    if (busy != 0) begin
    end else if (was_write) begin
      step = 3'h0;
      if (!supply_low_in && wr_armed) mem[a[7:0]] = wr_dq;
    end else begin
      if (step == 3'h5) begin
        case (a)
          `SEQ_ADDR_SAVE: if (!supply_low_in) begin
            nv = mem;
            saves++;
            busy = BUSY_CYC;
            wr_armed = 1'b0;
          end
          `SEQ_ADDR_RECALL: begin
            foreach (mem[i]) mem[i] = 8'h00;
            mem = nv;
            recalls++;
            wr_armed = 1'b0;
          end
          `SEQ_ADDR_PLS_OFF: pls_on = 1'b0;
          `SEQ_ADDR_PLS_ON: pls_on = 1'b1;
          default: ;
        endcase
      end
      step = (step != 3'h5 && a == seq[step]) ? step + 3'h1 :
        {2'b00, a == `SEQ_ADDR_0};
    end
  end
endmodule : nv_mem_model

// ---- tb/nv_host_seq_tb.sv ----
// self-checking bench for the host nonvolatile sequencer
// assumes nv_mem_model on the memory pins and a shortened save time
`timescale 1ns/100ps
module nv_host_seq_tb;
  import nv_host_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  nv_cmd_t cmd_in = '0;
  logic supply_low_in = 1'b0;
  logic cmd_ready_out;
  nv_rsp_t rsp_out;
  mem_pins_t pins_out;
  logic [7:0] dq_mem;
  logic [7:0] dq_wire;
  logic busy_b;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int lat;
  assign dq_wire = !pins_out.dq_drive_b ? pins_out.dq : dq_mem;
  always #50 ref_clk_in = ~ref_clk_in;
  nv_host_seq #(.STORE_CYC(20), .RECALL_CYC(2)) dut (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .rsp_out(rsp_out), .pins_out(pins_out),
    .dq_in(dq_wire), .store_busy_line_b_in(busy_b), .supply_low_in(supply_low_in));
  nv_mem_model model (.ref_clk_in(ref_clk_in), .pins_in(pins_out), .dq_in(dq_wire),
    .supply_low_in(supply_low_in), .dq_out(dq_mem), .busy_b_out(busy_b));
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // issue one command while ready is high, then wait for its answer
  task automatic do_cmd(input op_t op, input logic [16:0] a, input logic [7:0] d);
    cmd_in = '{op: op, addr: a, data: d};
    cmd_valid_in = 1'b1;
    @(posedge ref_clk_in);
    #1 cmd_valid_in = 1'b0;
    if (rsp_out.valid !== 1'b1) check("ready low", cmd_ready_out, 1'b0);
    lat = 1;
    while (rsp_out.valid !== 1'b1 && lat < 400) begin
      @(posedge ref_clk_in);
      #1 lat++;
    end
    if (lat >= 400) fails++;
  endtask : do_cmd
  task automatic t_write_read();
    do_cmd(OP_WRITE, 17'h1_0010, 8'h5A);
    do_cmd(OP_READ, 17'h1_0010, 8'h00);
    check("read data", rsp_out.data, 8'h5A);
    check("read time", lat, 7);
    check("ready back", cmd_ready_out, 1'b1);
  endtask : t_write_read
  task automatic t_save_recall();
    do_cmd(OP_SAVE, 17'h0, 8'h00);
    check("saves", model.saves, 1);
    check("busy wait", lat >= 55, 1'b1);
    do_cmd(OP_SAVE, 17'h0, 8'h00);
    check("saves again", model.saves, 2);
    do_cmd(OP_WRITE, 17'h1_0010, 8'hC3);
    check("write after save", model.mem[8'h10], 8'hC3);
    do_cmd(OP_RECALL, 17'h0, 8'h00);
    check("recalls", model.recalls, 1);
    check("nv kept", model.nv[8'h10], 8'h5A);
    do_cmd(OP_READ, 17'h1_0010, 8'h00);
    check("recalled data", rsp_out.data, 8'h5A);
  endtask : t_save_recall
  task automatic t_toggle();
    check("pls start", model.pls_on, 1'b1);
    do_cmd(OP_POWER_LOSS_SAVE_OFF, 17'h0, 8'h00);
    check("pls off", model.pls_on, 1'b0);
    check("save kept off", model.saves, 3);
    do_cmd(OP_POWER_LOSS_SAVE_ON, 17'h0, 8'h00);
    check("pls on", model.pls_on, 1'b1);
  endtask : t_toggle
  task automatic t_low_supply();
    supply_low_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1 do_cmd(OP_WRITE, 17'h1_0010, 8'h11);
    check("write refused", rsp_out.refused, 1'b1);
    do_cmd(OP_SAVE, 17'h0, 8'h00);
    check("save refused", rsp_out.refused, 1'b1);
    do_cmd(OP_READ, 17'h1_0010, 8'h00);
    check("read at low", rsp_out.data, 8'h5A);
    supply_low_in = 1'b0;
  endtask : t_low_supply
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1 rst_b_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1 t_write_read();
    t_save_recall();
    t_toggle();
    t_low_supply();
    give_verdict();
  end
endmodule : nv_host_seq_tb
